/* hdl/fhcr_mem.sv */
// Byte storage for the queue, registered read data
`timescale 1ns/1ps
module fhcr_mem (
   input  wire logic                     mclk,
   input  wire logic                     wr_en,
   input  wire logic [fhcr_pkg::AW-1:0]  wr_addr,
   input  wire logic [7:0]               wr_data,
   input  wire logic [fhcr_pkg::AW-1:0]  rd_addr,
   output logic      [7:0]               rd_data
);
   logic [7:0] store [fhcr_pkg::DEPTH];

   // Write and registered read; no reset so it maps to block RAM
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
      rd_data <= store[rd_addr];
   end
endmodule

/* hdl/fhcr_pkg.sv */
// Package: register map, field positions, reset values for the host control block
package fhcr_pkg;
   localparam logic [6:0] ADDR_COMMAND   = 7'h00;
   localparam logic [6:0] ADDR_OWNERSHIP = 7'h01;
   localparam logic [6:0] ADDR_QUEUE_CFG = 7'h02;
   localparam logic [6:0] ADDR_THRESHOLD = 7'h03;
   localparam logic [6:0] ADDR_FILL      = 7'h04;
   localparam logic [6:0] ADDR_PORT      = 7'h05;
   // Command register fields
   localparam int CMD_STANDBY_BIT  = 7;
   localparam int CMD_RADIO_OFF_BIT = 6;
   localparam int CMD_CODE_MSB     = 4;
   localparam logic [4:0] CMD_IDLE = 5'h00;
   // Ownership register fields
   localparam int OWN_UNLOCK_BIT = 7;
   localparam int OWN_HOST_BIT   = 6;
   localparam int OWN_SAM_BIT    = 5;
   localparam int OWN_PSEL_MSB   = 3;
   localparam int OWN_PSEL_LSB   = 2;
   localparam logic [1:0] PSEL_OFF = 2'h0;
   localparam logic [1:0] PSEL_SPI = 2'h1;
   localparam logic [1:0] PSEL_I2CL = 2'h2;
   localparam logic [1:0] PSEL_I2C = 2'h3;
   // Queue configuration fields
   localparam int QC_SIZE_BIT  = 7;
   localparam int QC_HIGH_BIT  = 6;
   localparam int QC_LOW_BIT   = 5;
   localparam int QC_CLEAR_BIT = 4;
   localparam int QC_THR_MSB_BIT = 2;
   // Capacities and depth
   localparam logic [9:0] CAP_SMALL = 10'h0ff;
   localparam logic [9:0] CAP_LARGE = 10'h200;
   localparam int DEPTH = 512;
   localparam int AW    = 9;
   // Reset values
   localparam logic [7:0] RST_COMMAND   = 8'h00;
   localparam logic [7:0] RST_THRESHOLD = 8'h00;
   localparam logic       RST_SIZE      = 1'b0;
endpackage

/* hdl/fhcr_top.sv */
// Host control registers and byte queue of the reader frontend
`timescale 1ns/1ps
module fhcr_top (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic [6:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   input  wire logic        cmd_done,
   input  wire logic [4:0]  cmd_done_code,
   output logic             power_down,
   output logic             radio_power_down,
   output logic [4:0]       command_code,
   output logic             host_owns_link,
   output logic             secure_module_owns_link,
   output logic [1:0]       secure_module_port_select,
   output logic             queue_nearly_full,
   output logic             queue_nearly_empty,
   output logic             queue_overflow
);
   // Per-access state of the register interface
   typedef enum logic [1:0] {
      FHCR_LOCKED   = 2'b01,
      FHCR_UNLOCKED = 2'b10
   } fhcr_lock_t;

   fhcr_lock_t       lock_state;
   logic             capacity_select;
   logic [7:0]       threshold_low_bits;
   logic             threshold_msb;
   logic [9:0]       fill_count;
   logic [8:0]       wr_ptr;
   logic [8:0]       rd_ptr;
   logic [7:0]       mem_rdata;
   logic [8:0]       next_rd_ptr;
   logic             head_fix_use;
   logic [7:0]       head_fix;

   // Threshold evaluated for the selected mode; the msb counts only in 512 mode
   function automatic logic [9:0] fhcr_thr(input logic big,
                                           input logic msb,
                                           input logic [7:0] lo);
      fhcr_thr = big ? {1'b0, msb, lo} : {2'b00, lo};
   endfunction

   // Address decode and strobes
   wire        wr_cmd      = reg_wr && (reg_addr == fhcr_pkg::ADDR_COMMAND);
   wire        wr_own      = reg_wr && (reg_addr == fhcr_pkg::ADDR_OWNERSHIP);
   wire        wr_qc       = reg_wr && (reg_addr == fhcr_pkg::ADDR_QUEUE_CFG);
   wire        wr_thr      = reg_wr && (reg_addr == fhcr_pkg::ADDR_THRESHOLD);
   wire        wr_port     = reg_wr && (reg_addr == fhcr_pkg::ADDR_PORT);
   wire        rd_port     = reg_rd && (reg_addr == fhcr_pkg::ADDR_PORT);
   wire        is_unlocked = (lock_state == FHCR_UNLOCKED);
   wire [9:0]  capacity    = capacity_select ? fhcr_pkg::CAP_SMALL
                                             : fhcr_pkg::CAP_LARGE;
   wire [9:0]  threshold   = fhcr_thr(capacity_select == 1'b0,
                                      threshold_msb, threshold_low_bits);
   wire        queue_empty = (fill_count == 10'h000);
   wire        queue_full  = (fill_count >= capacity);
   wire        qclear      = wr_qc && reg_wdata[fhcr_pkg::QC_CLEAR_BIT];
   wire        do_push     = wr_port && !queue_full && !qclear;
   wire        do_pop      = rd_port && !queue_empty && !qclear;

   // Ownership write is honoured only when unlocked and not both bits set
   wire        own_req_h   = reg_wdata[fhcr_pkg::OWN_HOST_BIT];
   wire        own_req_s   = reg_wdata[fhcr_pkg::OWN_SAM_BIT];
   wire        own_ok      = wr_own && is_unlocked
                             && !(own_req_h && own_req_s);
   wire        unlock_req  = wr_own && reg_wdata[fhcr_pkg::OWN_UNLOCK_BIT];

   // Alert flags from count, capacity and threshold
   wire        next_high   = ((capacity - fill_count) <= threshold);
   wire        next_low    = (fill_count <= threshold);

   // Count after this cycle's push, pop or clear
   logic [9:0] next_fill;
   always_comb begin
      next_fill = fill_count;
      if (qclear) begin
         next_fill = 10'h000;
      end else if (do_push && !do_pop) begin
         next_fill = fill_count + 10'h001;
      end else if (do_pop && !do_push) begin
         next_fill = fill_count - 10'h001;
      end
   end

   // Read mux; write-only clear bit and reserved bits read zero
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_addr)
         fhcr_pkg::ADDR_COMMAND:
            next_rdata = {power_down, radio_power_down, 1'b0,
                          command_code};
         fhcr_pkg::ADDR_OWNERSHIP:
            next_rdata = {is_unlocked, host_owns_link,
                          secure_module_owns_link, 1'b0,
                          secure_module_port_select, 2'b00};
         fhcr_pkg::ADDR_QUEUE_CFG:
            next_rdata = {capacity_select, queue_nearly_full,
                          queue_nearly_empty, 1'b0, 1'b0,
                          threshold_msb, fill_count[9:8]};
         fhcr_pkg::ADDR_THRESHOLD:
            next_rdata = threshold_low_bits;
         fhcr_pkg::ADDR_FILL:
            next_rdata = fill_count[7:0];
         default:
            next_rdata = 8'h00;
      endcase
   end

   // Queue storage; pointers wrap at the selected capacity
   fhcr_mem u_mem (
      .mclk    (mclk),
      .wr_en   (do_push),
      .wr_addr (wr_ptr),
      .wr_data (reg_wdata),
      .rd_addr (next_rd_ptr),
      .rd_data (mem_rdata)
   );

   function automatic logic [8:0] fhcr_inc(input logic [8:0] p,
                                           input logic [9:0] cap);
      fhcr_inc = ({1'b0, p} == cap - 10'h001) ? 9'h000 : p + 9'h001;
   endfunction

   // Read pointer after this edge; memory reads ahead so the head
   // byte is already registered when the host reads the port
   always_comb begin
      next_rd_ptr = rd_ptr;
      if (qclear) begin
         next_rd_ptr = 9'h000;
      end else if (do_pop) begin
         next_rd_ptr = fhcr_inc(rd_ptr, capacity);
      end
   end

   // A push into the slot being fetched shows at the memory output one
   // cycle late, so a copy of that byte stands in for that cycle
   wire        head_hazard = do_push && (wr_ptr == next_rd_ptr);
   wire [7:0]  head_byte   = head_fix_use ? head_fix : mem_rdata;

   // Bypass copy of the byte just pushed
   always_ff @(posedge mclk) begin
      if (srst) begin
         head_fix_use <= 1'b0;
         head_fix     <= 8'h00;
      end else begin
         head_fix_use <= head_hazard;
         head_fix     <= reg_wdata;
      end
   end

   // Command register; device rewrites code when a command finishes
   always_ff @(posedge mclk) begin
      if (srst) begin
         power_down       <= fhcr_pkg::RST_COMMAND[7];
         radio_power_down <= fhcr_pkg::RST_COMMAND[6];
         command_code     <= fhcr_pkg::CMD_IDLE;
      end else if (wr_cmd) begin
         power_down       <= reg_wdata[fhcr_pkg::CMD_STANDBY_BIT];
         radio_power_down <= reg_wdata[fhcr_pkg::CMD_RADIO_OFF_BIT];
         command_code     <= reg_wdata[fhcr_pkg::CMD_CODE_MSB:0];
      end else if (cmd_done) begin
         command_code     <= cmd_done_code;
      end
   end

   // Unlock: set by a write of bit7, dropped by the next write anywhere that is not another bit7 unlock
   always_ff @(posedge mclk) begin
      if (srst) begin
         lock_state <= FHCR_LOCKED;
      end else if (unlock_req) begin
         lock_state <= FHCR_UNLOCKED;
      end else if (reg_wr) begin
         lock_state <= FHCR_LOCKED;
      end
   end

   // Ownership and module port select
   always_ff @(posedge mclk) begin
      if (srst) begin
         host_owns_link            <= 1'b0;
         secure_module_owns_link   <= 1'b0;
         secure_module_port_select <= fhcr_pkg::PSEL_OFF;
      end else if (own_ok) begin
         host_owns_link            <= own_req_h;
         secure_module_owns_link   <= own_req_s;
         secure_module_port_select <=
            reg_wdata[fhcr_pkg::OWN_PSEL_MSB:fhcr_pkg::OWN_PSEL_LSB];
      end
   end

   // Queue configuration and threshold registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         capacity_select    <= fhcr_pkg::RST_SIZE;
         threshold_msb      <= 1'b0;
         threshold_low_bits <= fhcr_pkg::RST_THRESHOLD;
      end else begin
         if (wr_qc) begin
            // Size change is not blocked; host clears first
            capacity_select <= reg_wdata[fhcr_pkg::QC_SIZE_BIT];
            threshold_msb   <= reg_wdata[fhcr_pkg::QC_THR_MSB_BIT];
         end
         if (wr_thr) begin
            threshold_low_bits <= reg_wdata;
         end
      end
   end

   // Pointers, count and overflow pulse
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_ptr         <= 9'h000;
         rd_ptr         <= 9'h000;
         fill_count     <= 10'h000;
         queue_overflow <= 1'b0;
      end else begin
         fill_count     <= next_fill;
         queue_overflow <= wr_port && queue_full && !qclear;
         if (qclear) begin
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
         end else begin
            if (do_push) begin
               wr_ptr <= fhcr_inc(wr_ptr, capacity);
            end
            if (do_pop) begin
               rd_ptr <= fhcr_inc(rd_ptr, capacity);
            end
         end
      end
   end

   // Alerts registered from the count before this cycle's update
   always_ff @(posedge mclk) begin
      if (srst) begin
         queue_nearly_full  <= 1'b0;
         queue_nearly_empty <= 1'b1;
      end else begin
         queue_nearly_full  <= next_high;
         queue_nearly_empty <= next_low;
      end
   end

   // Read strobe answered one cycle later
   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

   // Port reads return the head byte; an empty port reads zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= do_pop ? head_byte : next_rdata;
      end
   end

   // Checks
   AST_OWN_EXCL: assert property (@(posedge mclk) disable iff (srst)
      !(host_owns_link && secure_module_owns_link))
      else $error("both ownership bits set");
   AST_LOCKED_KEEP: assert property (@(posedge mclk) disable iff (srst)
      (wr_own && !is_unlocked) |=> $stable(host_owns_link)
         && $stable(secure_module_owns_link)
         && $stable(secure_module_port_select))
      else $error("locked write changed ownership");
   AST_UNLOCK_DROP: assert property (@(posedge mclk) disable iff (srst)
      (reg_wr && !unlock_req) |=> !is_unlocked)
      else $error("unlock survived a write");
   AST_HOST_GRANT: assert property (@(posedge mclk) disable iff (srst)
      (wr_own && is_unlocked && own_req_h && !own_req_s)
         |=> host_owns_link)
      else $error("host grant lost");
   AST_SAM_GRANT: assert property (@(posedge mclk) disable iff (srst)
      (wr_own && is_unlocked && own_req_s && !own_req_h)
         |=> secure_module_owns_link && !host_owns_link)
      else $error("module grant lost");
   AST_CLEAR: assert property (@(posedge mclk) disable iff (srst)
      qclear |=> fill_count == 10'h000 ##1 queue_nearly_empty)
      else $error("clear did not empty queue");
   AST_PUSH: assert property (@(posedge mclk) disable iff (srst)
      (do_push && !do_pop && !qclear)
         |=> fill_count == $past(fill_count) + 10'h001)
      else $error("push did not count");
   AST_POP: assert property (@(posedge mclk) disable iff (srst)
      (do_pop && !do_push && !qclear)
         |=> fill_count == $past(fill_count) - 10'h001)
      else $error("pop did not count");
   AST_CMD_DONE: assert property (@(posedge mclk) disable iff (srst)
      (cmd_done && !wr_cmd) |=> command_code == $past(cmd_done_code))
      else $error("command field not rewritten");
   AST_LOW: assert property (@(posedge mclk) disable iff (srst)
      queue_nearly_empty == ($past(fill_count) <= $past(threshold)))
      else $error("low alert wrong");
   AST_HIGH: assert property (@(posedge mclk) disable iff (srst)
      queue_nearly_full
         == ($past(capacity - fill_count) <= $past(threshold)))
      else $error("high alert wrong");
   AST_STANDBY: assert property (@(posedge mclk) disable iff (srst)
      wr_cmd |=> power_down == $past(reg_wdata[fhcr_pkg::CMD_STANDBY_BIT])
         && radio_power_down
            == $past(reg_wdata[fhcr_pkg::CMD_RADIO_OFF_BIT]))
      else $error("power bits not taken from write");
   AST_EMPTY_READ: assert property (@(posedge mclk) disable iff (srst)
      (rd_port && queue_empty)
         |=> reg_rdata == 8'h00 && fill_count == 10'h000)
      else $error("empty port read changed count or data");
endmodule

/* test/fhcr_host_model.sv */
// Host microcontroller model driving the register access strobes
`timescale 1ns/1ps
module fhcr_host_model (
   input  wire logic        mclk,
   output logic      [6:0]  reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [7:0]  reg_wdata,
   input  wire logic [7:0]  reg_rdata,
   input  wire logic        reg_rvalid
);
   logic [7:0] last_rdata;
   logic       rd_ok;

   // Idle bus at time zero, no strobe raised before reset release
   initial begin
      reg_addr   = 7'h7f;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      reg_wdata  = 8'h00;
      last_rdata = 8'h00;
   end

   // One write, held until the taking edge; data inverted once released
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d; // Stale data must not pass for a fresh value
   endtask

   // One read; answer taken at a rising edge within a bounded wait
   task automatic rd(input logic [6:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd     <= 1'b0;
      rd_ok      = 1'b0;
      last_rdata = 8'hxx; // A missing answer then fails the compare
      for (int i = 0; i < 4 && !rd_ok; i++) begin
         @(posedge mclk);
         if (reg_rvalid === 1'b1) begin
            rd_ok      = 1'b1;
            last_rdata = reg_rdata;
         end
      end
   endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the host control registers and byte queue
`timescale 1ns/1ps
module testbench;
   logic       mclk;
   logic       srst;
   logic [6:0] reg_addr;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       reg_rvalid;
   logic       cmd_done;
   logic [4:0] cmd_done_code;
   logic       power_down;
   logic       radio_power_down;
   logic [4:0] command_code;
   logic       host_owns;
   logic       sam_owns;
   logic [1:0] port_sel;
   logic       nearly_full;
   logic       nearly_empty;
   logic       queue_overflow;
   logic       ovf_seen;
   int         mismatches;
   int         n_tests;
   int         cycles;

   fhcr_top uut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .cmd_done(cmd_done), .cmd_done_code(cmd_done_code),
      .power_down(power_down), .radio_power_down(radio_power_down),
      .command_code(command_code), .host_owns_link(host_owns),
      .secure_module_owns_link(sam_owns),
      .secure_module_port_select(port_sel),
      .queue_nearly_full(nearly_full), .queue_nearly_empty(nearly_empty),
      .queue_overflow(queue_overflow));

   fhcr_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   // 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Overflow is a one-cycle pulse, so keep a sticky copy; hang guard
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (queue_overflow === 1'b1)
         ovf_seen <= 1'b1;
      if (cycles == 6000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      host.rd(a);
      chk(host.last_rdata, exp);
   endtask

   // Alerts lag the count by a cycle, so let two edges pass
   task automatic settle;
      repeat (2) @(posedge mclk);
      #2;
   endtask

   // Bytes a5, a6 and on, so the read order shows
   task automatic push(input int n);
      for (int k = 0; k < n; k++)
         host.wr(7'h05, 8'(k) + 8'ha5);
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      srst          = 1'b1;
      cmd_done      = 1'b0;
      cmd_done_code = 5'h00;
      ovf_seen      = 1'b0;
      cycles        = 0;
      mismatches    = 0;
      n_tests       = 0;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      settle();
      chk(8'(nearly_empty), 8'h01);
      rchk(7'h00, 8'h00);
      rchk(7'h02, 8'h20);
      rchk(7'h03, 8'h00);
      // Command register and self-update after completion
      host.wr(7'h00, 8'hc5);
      settle();
      chk(8'(power_down), 8'h01);
      chk(8'(radio_power_down), 8'h01);
      chk(8'(command_code), 8'h05);
      rchk(7'h00, 8'hc5);
      @(posedge mclk);
      cmd_done      <= 1'b1;
      cmd_done_code <= 5'h03;
      @(posedge mclk);
      cmd_done <= 1'b0;
      settle();
      rchk(7'h00, 8'hc3);
      host.wr(7'h00, 8'h00);
      settle();
      chk(8'(power_down), 8'h00);
      // Locked write refused, unlocked write applied, unlock self-clears
      host.wr(7'h01, 8'h44);
      settle();
      chk(8'(host_owns), 8'h00);
      host.wr(7'h01, 8'h80);
      host.wr(7'h01, 8'h44);
      settle();
      chk(8'(host_owns), 8'h01);
      rchk(7'h01, 8'h44);
      for (int p = 0; p < 4; p++) begin
         host.wr(7'h01, 8'h80);
         host.wr(7'h01, 8'h20 | 8'(p << 2));
         settle();
         chk(8'({host_owns, sam_owns}), 8'h01);
         chk(8'(port_sel), 8'(p));
      end
      host.wr(7'h01, 8'h80);
      host.wr(7'h01, 8'h64);
      settle();
      chk(8'({host_owns, sam_owns, port_sel}), 8'h07);
      host.wr(7'h01, 8'h80);
      host.wr(7'h03, 8'h02);
      host.wr(7'h01, 8'h44);
      settle();
      chk(8'({host_owns, sam_owns, port_sel}), 8'h07);
      // Count, alerts and extended threshold in 512 mode
      push(3);
      settle();
      rchk(7'h04, 8'h03);
      chk(8'(nearly_empty), 8'h00);
      rchk(7'h05, 8'ha5);
      settle();
      rchk(7'h04, 8'h02);
      chk(8'({nearly_full, nearly_empty}), 8'h01);
      host.wr(7'h03, 8'hff);
      host.wr(7'h02, 8'h04);
      settle();
      chk(8'(nearly_full), 8'h01);
      rchk(7'h03, 8'hff);
      rchk(7'h02, 8'h64);
      host.wr(7'h02, 8'h14);
      settle();
      rchk(7'h04, 8'h00);
      rchk(7'h02, 8'h24);
      rchk(7'h05, 8'h00);
      settle();
      rchk(7'h04, 8'h00);
      // Small mode filled to refusal; size changed only when empty
      host.wr(7'h02, 8'h80);
      host.wr(7'h03, 8'h00);
      push(255);
      settle();
      rchk(7'h04, 8'hff);
      rchk(7'h02, 8'hc0);
      chk(8'(ovf_seen), 8'h00);
      push(1);
      settle();
      chk(8'(ovf_seen), 8'h01);
      rchk(7'h04, 8'hff);
      rchk(7'h05, 8'ha5);
      rchk(7'h04, 8'hfe);
      host.wr(7'h02, 8'h90);
      host.wr(7'h02, 8'h00);
      push(300);
      settle();
      rchk(7'h04, 8'h2c);
      rchk(7'h02, 8'h01);
      rchk(7'h05, 8'ha5);
      rchk(7'h04, 8'h2b);
      end_sim();
   end
endmodule
